// ---- dual_timer.sv ----
// Behaviour
// - Mode 0 counts thirteen bits: high byte plus low five bits of low byte.
// - Mode 0 wrap from all ones to zero sets the timer overflow flag.
// - A timer counts only with run bit set and gate clear or pin high; timer one ignores its run bit while timer zero is split.
// - Setting the run bit keeps the count; counting resumes from it.
// - Mode 0 upper three low-byte bits are outside the count; ignore them.
// - Mode 01b cascades both bytes into sixteen bits; overflow sets flag.
// - Mode 10b counts low byte, reloads it from high byte on overflow.
// - Timer one in mode 3 freezes as if its run bit were clear.
// - Timer zero mode 3 low byte uses all timer zero controls and flag.
// - Timer zero mode 3 high byte ticks internally, uses timer one run/flag.
// - Timer one still overflows flaglessly while timer zero is split.
// - Function bit picks internal ticks (0) or count pin events (1).
// - Mode register holds one two-bit mode field for each timer.
// - External interrupt flags set when their pin becomes active.
// - Trigger type bits pick edge or level sensing per pin.
// - Trigger type 1 means falling edge, 0 means low level.
// - Timer function advances once every twelve oscillator cycles.
// - Count pin sampled each tick; one then zero increments next tick.
// - Overflow flags clear by hardware once firmware serviced them.
module dual_timer (
    input wire logic I_CLK,
    input wire logic I_RSTN,
    input wire logic [7:0] I_ADDR,
    input wire logic [7:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic I_EVENT_PIN_ZERO,
    input wire logic I_EVENT_PIN_ONE,
    input wire logic I_EXT_IRQ_PIN_ZERO,
    input wire logic I_EXT_IRQ_PIN_ONE,
    input wire logic I_SERVICED_TIMER_ZERO,
    input wire logic I_SERVICED_TIMER_ONE,
    input wire logic I_SERVICED_EXT_ZERO,
    input wire logic I_SERVICED_EXT_ONE,
    output logic [7:0] O_RDATA,
    output logic O_OVERFLOW_FLAG_ZERO,
    output logic O_OVERFLOW_FLAG_ONE,
    output logic O_EXT_IRQ_FLAG_ZERO,
    output logic O_EXT_IRQ_FLAG_ONE,
    output logic O_TIMER_ONE_OVERFLOW
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic rst_n;

    // Reset asserts at once but leaves on the clock to avoid recovery races.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    // ------------------------------------------------------------
    // Tick and count pin sampling
    // ------------------------------------------------------------
    logic tick;
    logic [1:0] ev_inc;
    logic [1:0] ev_pin;

    assign ev_pin = {I_EVENT_PIN_ONE, I_EVENT_PIN_ZERO};

    osc_tick #(
        .DIVIDE(tmr_pkg::OSC_CYCLES_PER_TICK)
    ) u_tick (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .o_tick(tick)
    );

    for (genvar g = 0; g < 2; g++) begin : g_ev
        event_sampler u_ev (
            .i_clk(I_CLK),
            .i_rst_n(rst_n),
            .i_pin(ev_pin[g]),
            .i_tick(tick),
            .o_inc(ev_inc[g])
        );
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] mode_sel;
        logic run0;
        logic run1;
        logic trig0;
        logic trig1;
        logic ovf0;
        logic ovf1;
        logic xflag0;
        logic xflag1;
        logic [7:0] low0;
        logic [7:0] high0;
        logic [7:0] low1;
        logic [7:0] high1;
        logic [1:0] xsync_a;
        logic [1:0] xsync_b;
        logic [1:0] xprev;
        logic [7:0] rdata;
        logic t1_pulse;
    } state_t;

    state_t q;
    state_t next_q;

    // Step one timer in modes 0 to 2; the result is {overflow, high, low}.
    function automatic logic [16:0] step_timer(input logic [1:0] md, input logic [7:0] lo,
                                               input logic [7:0] hi, input logic inc);
        logic [12:0] c13;
        logic [15:0] c16;
        logic [16:0] r;
        c13 = {hi, lo[4:0]} + 13'h0001;
        c16 = {hi, lo} + 16'h0001;
        r = {1'b0, hi, lo};
        if (inc) begin
            unique case (tmr_pkg::mode_t'(md))
                tmr_pkg::MODE_PRESCALED_13: begin
                    r = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
                end
                tmr_pkg::MODE_CASCADED_16: begin
                    r = {&{hi, lo}, c16};
                end
                tmr_pkg::MODE_RELOAD_8: begin
                    r = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
                end
                tmr_pkg::MODE_SPLIT_STOP: begin
                    r = {1'b0, hi, lo};
                end
            endcase
        end
        return r;
    endfunction

    // Register read decode, used by the read path.
    function automatic logic [7:0] read_reg(input state_t s, input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            tmr_pkg::ADDR_SHARED_CONTROL: v = {s.ovf1, s.run1, s.ovf0, s.run0,
                                               s.xflag1, s.trig1, s.xflag0, s.trig0};
            tmr_pkg::ADDR_MODE_SELECT: v = s.mode_sel;
            tmr_pkg::ADDR_COUNT_LOW_ZERO: v = s.low0;
            tmr_pkg::ADDR_COUNT_LOW_ONE: v = s.low1;
            tmr_pkg::ADDR_COUNT_HIGH_ZERO: v = s.high0;
            tmr_pkg::ADDR_COUNT_HIGH_ONE: v = s.high1;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    logic [1:0] md0;
    logic [1:0] md1;
    logic split0;
    logic en0;
    logic en1;
    logic inc0;
    logic inc1;
    logic inc_high0;
    logic [16:0] res0;
    logic [16:0] res1;
    logic ovf_low0;
    logic ovf_high0;
    logic set_ovf0;
    logic set_ovf1;
    logic [1:0] xset;
    logic [1:0] fall;
    logic wr_ctl;

    // Mode fields and enables; timer one ignores its run bit while timer
    // zero is split, and stops only by entering its own mode 3 or through its gate.
    always_comb begin
        md0 = q.mode_sel[tmr_pkg::MODE_FIELD_LSB +: 2];
        md1 = q.mode_sel[tmr_pkg::MODE_NIBBLE_ONE + tmr_pkg::MODE_FIELD_LSB +: 2];
        split0 = (md0 == tmr_pkg::MODE_SPLIT_STOP);
        en0 = q.run0 && (!q.mode_sel[tmr_pkg::MODE_GATE_BIT] || q.xsync_b[0]);
        en1 = (split0 || q.run1)
            && (!q.mode_sel[tmr_pkg::MODE_NIBBLE_ONE + tmr_pkg::MODE_GATE_BIT] || q.xsync_b[1]);
        inc0 = en0 && (q.mode_sel[tmr_pkg::MODE_FUNC_BIT] ? ev_inc[0] : tick);
        inc1 = en1 && (md1 != tmr_pkg::MODE_SPLIT_STOP)
            && (q.mode_sel[tmr_pkg::MODE_NIBBLE_ONE + tmr_pkg::MODE_FUNC_BIT] ? ev_inc[1] : tick);
        inc_high0 = split0 && q.run1 && tick;
    end

    // Counting results of both timers, split mode handled separately.
    always_comb begin
        res0 = step_timer(md0, q.low0, q.high0, inc0 && !split0);
        res1 = step_timer(md1, q.low1, q.high1, inc1);
        ovf_low0 = split0 && inc0 && (&q.low0);
        ovf_high0 = inc_high0 && (&q.high0);
        set_ovf0 = res0[16] || ovf_low0;
        set_ovf1 = split0 ? ovf_high0 : res1[16];
    end

    // External pin sensing: low level or a fall between two synced samples.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            fall[i] = q.xprev[i] && !q.xsync_b[i];
        end
        xset[0] = q.trig0 ? fall[0] : !q.xsync_b[0];
        xset[1] = q.trig1 ? fall[1] : !q.xsync_b[1];
        wr_ctl = I_WR && (I_ADDR == tmr_pkg::ADDR_SHARED_CONTROL);
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Hardware setting a flag beats servicing in the same cycle so that
    // an overflow or pin event is never dropped.
    always_comb begin
        next_q = q;
        next_q.xsync_a = {I_EXT_IRQ_PIN_ONE, I_EXT_IRQ_PIN_ZERO};
        next_q.xsync_b = q.xsync_a;
        next_q.xprev = q.xsync_b;
        next_q.rdata = I_RD ? read_reg(q, I_ADDR) : 8'h00;
        next_q.t1_pulse = res1[16];
        {next_q.high1, next_q.low1} = res1[15:0];
        if (split0) begin
            next_q.low0 = inc0 ? q.low0 + 8'h01 : q.low0;
            next_q.high0 = inc_high0 ? q.high0 + 8'h01 : q.high0;
        end else begin
            {next_q.high0, next_q.low0} = res0[15:0];
        end
        if (set_ovf0) begin
            next_q.ovf0 = 1'b1;
        end else if (I_SERVICED_TIMER_ZERO) begin
            next_q.ovf0 = 1'b0;
        end
        if (set_ovf1) begin
            next_q.ovf1 = 1'b1;
        end else if (I_SERVICED_TIMER_ONE) begin
            next_q.ovf1 = 1'b0;
        end
        if (xset[0]) begin
            next_q.xflag0 = 1'b1;
        end else if (I_SERVICED_EXT_ZERO) begin
            next_q.xflag0 = 1'b0;
        end
        if (xset[1]) begin
            next_q.xflag1 = 1'b1;
        end else if (I_SERVICED_EXT_ONE) begin
            next_q.xflag1 = 1'b0;
        end
        if (wr_ctl) begin
            next_q.run0 = I_WDATA[tmr_pkg::CTL_RUN_BIT_ZERO];
            next_q.run1 = I_WDATA[tmr_pkg::CTL_RUN_BIT_ONE];
            next_q.trig0 = I_WDATA[tmr_pkg::CTL_TRIGGER_TYPE_ZERO];
            next_q.trig1 = I_WDATA[tmr_pkg::CTL_TRIGGER_TYPE_ONE];
        end
        if (I_WR) begin
            unique case (I_ADDR)
                tmr_pkg::ADDR_MODE_SELECT: next_q.mode_sel = I_WDATA;
                tmr_pkg::ADDR_COUNT_LOW_ZERO: next_q.low0 = I_WDATA;
                tmr_pkg::ADDR_COUNT_LOW_ONE: next_q.low1 = I_WDATA;
                tmr_pkg::ADDR_COUNT_HIGH_ZERO: next_q.high0 = I_WDATA;
                tmr_pkg::ADDR_COUNT_HIGH_ONE: next_q.high1 = I_WDATA;
                default: next_q.mode_sel = next_q.mode_sel;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            {q.xsync_a, q.xsync_b, q.xprev} <= 6'h3F;
            q.mode_sel <= tmr_pkg::RST_MODE_SELECT;
            q.low0 <= tmr_pkg::RST_COUNT;
            q.high0 <= tmr_pkg::RST_COUNT;
            q.low1 <= tmr_pkg::RST_COUNT;
            q.high1 <= tmr_pkg::RST_COUNT;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_RDATA = q.rdata;
    assign O_OVERFLOW_FLAG_ZERO = q.ovf0;
    assign O_OVERFLOW_FLAG_ONE = q.ovf1;
    assign O_EXT_IRQ_FLAG_ZERO = q.xflag0;
    assign O_EXT_IRQ_FLAG_ONE = q.xflag1;
    assign O_TIMER_ONE_OVERFLOW = q.t1_pulse;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic no_wr;
    assign no_wr = !I_WR;

    sequence wrap13_s;
        md0 == tmr_pkg::MODE_PRESCALED_13 && inc0 && {q.high0, q.low0[4:0]} == 13'h1FFF && no_wr;
    endsequence

    sequence cleared13_s;
        q.ovf0 && q.high0 == 8'h00 && q.low0[4:0] == 5'h00;
    endsequence

    tick_period_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        tick |-> ##12 tick) else $error("tick period is not twelve cycles");

    gate_hold_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (!en0 && no_wr && !split0) |=> $stable({q.high0, q.low0})) else $error("timer zero moved while disabled");

    wrap_mode0_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        wrap13_s |=> cleared13_s) else $error("mode zero wrap wrong");

    reload_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (md0 == tmr_pkg::MODE_RELOAD_8 && inc0 && q.low0 == 8'hFF && no_wr)
        |=> (q.low0 == $past(q.high0) && q.ovf0 && $stable(q.high0))) else $error("reload failed");

    freeze_one_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (md1 == tmr_pkg::MODE_SPLIT_STOP && no_wr) |=> $stable({q.high1, q.low1})) else $error("timer one moved");

    split_high_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (split0 && q.run1 && tick && q.high0 == 8'hFF && no_wr) |=> (q.ovf1 && q.high0 == 8'h00))
        else $error("split high byte overflow wrong");

    service_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (I_SERVICED_TIMER_ZERO && !set_ovf0) |=> !q.ovf0) else $error("serviced flag not cleared");

    edge_flag_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (q.trig0 && q.xprev[0] && !q.xsync_b[0]) |=> q.xflag0) else $error("falling edge missed");

    level_flag_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        (!q.trig0 && !q.xsync_b[0]) |=> q.xflag0 [*1]) else $error("low level missed");

    count_event_a: assert property (@(posedge I_CLK) disable iff (!rst_n)
        ev_inc[0] |-> $past(tick) ##1 !ev_inc[0]) else $error("event increment off tick");

endmodule

// ---- dual_timer_counter_modes_bench.sv ----
module dual_timer_counter_modes_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Nets and counters
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] svc = 4'h0;
    logic ev0, ev1, irq0, irq1, ovf0, ovf1, xf0, xf1, t1ovf;
    logic [7:0] rdata;
    logic [7:0] v;
    int num_errors = 0;
    int num_checks = 0;

    dual_timer dut (
        .I_CLK(clk), .I_RSTN(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .I_EVENT_PIN_ZERO(ev0), .I_EVENT_PIN_ONE(ev1), .I_EXT_IRQ_PIN_ZERO(irq0), .I_EXT_IRQ_PIN_ONE(irq1),
        .I_SERVICED_TIMER_ZERO(svc[0]), .I_SERVICED_TIMER_ONE(svc[1]),
        .I_SERVICED_EXT_ZERO(svc[2]), .I_SERVICED_EXT_ONE(svc[3]), .O_RDATA(rdata),
        .O_OVERFLOW_FLAG_ZERO(ovf0), .O_OVERFLOW_FLAG_ONE(ovf1), .O_EXT_IRQ_FLAG_ZERO(xf0),
        .O_EXT_IRQ_FLAG_ONE(xf1), .O_TIMER_ONE_OVERFLOW(t1ovf)
    );

    pin_partner pins (.i_clk(clk), .o_event_zero(ev0), .o_event_one(ev1), .o_irq_zero(irq0), .o_irq_one(irq1));

    // 40 MHz oscillator.
    initial begin
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic fail(input string m);
        $display("[FAIL] %0t %s", $time, m);
        num_errors++;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
    endtask

    task automatic rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        num_checks++;
        if (!(got >= lo && got <= hi)) fail($sformatf("got %h outside %h..%h", got, lo, hi));
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the taken edge, so sample there.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic service(input int idx);
        @(posedge clk);
        svc[idx] <= 1'b1;
        @(posedge clk);
        svc[idx] <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Bounded wait; bit order t1ovf, xf1, xf0, ovf1, ovf0.
    task automatic wait_sig(input int sel);
        logic [4:0] s;
        for (int n = 0; n < 400; n++) begin
            @(posedge clk);
            #1;
            s = {t1ovf, xf1, xf0, ovf1, ovf0};
            if (s[sel] === 1'b1) return;
        end
        fail("wait for output timed out");
    endtask

    task automatic done(input string name);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h00);
        $display("test %s done", name);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        chk({3'b000, t1ovf, xf1, xf0, ovf1, ovf0}, 8'h00);
        for (int a = 8'h88; a <= 8'h8D; a++) begin
            rd_reg(8'(a), v);
            chk(v, 8'h00);
        end
        rd_reg(8'h90, v);
        chk(v, 8'h00);
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h5A);
        rd_reg(tmr_pkg::ADDR_MODE_SELECT, v);
        chk(v, 8'h5A);
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h00);
        // Flag bits are hardware owned; a write of only those bits changes nothing.
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'hAA);
        rd_reg(tmr_pkg::ADDR_SHARED_CONTROL, v);
        chk(v, 8'h00);
        done("reset");
    endtask

    task automatic t_reload();
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h02);
        wr_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, 8'h80);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, 8'hFE);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h10);
        wait_sig(0);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, v);
        chk(v, 8'h80);
        rd_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, v);
        chk(v, 8'h80);
        service(0);
        chk({7'h00, ovf0}, 8'h00);
        done("reload");
    endtask

    task automatic t_wide();
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h01);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, 8'h00);
        wr_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, 8'h00);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h10);
        repeat (120) @(posedge clk);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h00);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, v);
        rng(v, 8'h09, 8'h0B);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, 8'hFF);
        wr_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, 8'hFF);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h10);
        wait_sig(0);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, v);
        chk(v, 8'h00);
        rd_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, v);
        chk(v, 8'h00);
        service(0);
        done("wide");
    endtask

    task automatic t_prescale();
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h00);
        wr_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, 8'hFF);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, 8'hFE);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h10);
        wait_sig(0);
        rd_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, v);
        chk(v, 8'h00);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, v);
        chk(v & 8'h1F, 8'h00);
        service(0);
        done("prescale");
    endtask

    task automatic t_gate();
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h09);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, 8'h40);
        pins.set_irq(0, 1'b0);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h10);
        repeat (60) @(posedge clk);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, v);
        chk(v, 8'h40);
        pins.set_irq(0, 1'b1);
        repeat (60) @(posedge clk);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h00);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, v);
        rng(v, 8'h44, 8'h46);
        service(2);
        done("gate");
    endtask

    task automatic t_events();
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h55);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, 8'h00);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ONE, 8'h00);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h50);
        pins.pulse_events(5);
        repeat (48) @(posedge clk);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h00);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, v);
        chk(v, 8'h05);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ONE, v);
        chk(v, 8'h05);
        done("events");
    endtask

    task automatic t_freeze();
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h30);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ONE, 8'h10);
        wr_reg(tmr_pkg::ADDR_COUNT_HIGH_ONE, 8'h00);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h40);
        repeat (60) @(posedge clk);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ONE, v);
        chk(v, 8'h10);
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h10);
        repeat (60) @(posedge clk);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h00);
        rd_reg(tmr_pkg::ADDR_COUNT_LOW_ONE, v);
        rng(v, 8'h14, 8'h16);
        done("freeze");
    endtask

    // Each wraps on its second tick, and flag zero is sticky.
    task automatic t_split();
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ZERO, 8'hFE);
        wr_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, 8'h00);
        wr_reg(tmr_pkg::ADDR_COUNT_LOW_ONE, 8'hFE);
        wr_reg(tmr_pkg::ADDR_COUNT_HIGH_ONE, 8'hFF);
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h13);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h10);
        wait_sig(4);
        wait_sig(0);
        chk({7'h00, ovf1}, 8'h00);
        rd_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, v);
        chk(v, 8'h00);
        wr_reg(tmr_pkg::ADDR_COUNT_HIGH_ZERO, 8'hFF);
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h50);
        wait_sig(1);
        wr_reg(tmr_pkg::ADDR_MODE_SELECT, 8'h00);
        service(0);
        service(1);
        done("split");
    endtask

    task automatic t_ext();
        wr_reg(tmr_pkg::ADDR_SHARED_CONTROL, 8'h01);
        pins.set_irq(0, 1'b0);
        wait_sig(2);
        service(2);
        repeat (3) @(posedge clk);
        chk({7'h00, xf0}, 8'h00);
        pins.set_irq(0, 1'b1);
        pins.set_irq(1, 1'b0);
        wait_sig(3);
        service(3);
        repeat (3) @(posedge clk);
        chk({7'h00, xf1}, 8'h01);
        rd_reg(tmr_pkg::ADDR_SHARED_CONTROL, v);
        chk(v, 8'h09);
        pins.set_irq(1, 1'b1);
        repeat (4) @(posedge clk);
        service(3);
        chk({7'h00, xf1}, 8'h00);
        done("ext");
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // The sequence needs about a thousand cycles; this margin only catches a hang.
    initial begin
        #(30000 * 25);
        fail("watchdog expired");
        summarize();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_reload();
        t_wide();
        t_prescale();
        t_gate();
        t_events();
        t_freeze();
        t_split();
        t_ext();
        summarize();
    end
endmodule

// ---- event_sampler.sv ----
module event_sampler (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    input wire logic i_tick,
    output logic o_inc
);

    typedef struct packed {
        logic sync_a;
        logic sync_b;
        logic older;
        logic newer;
        logic inc;
    } state_t;

    state_t q;
    state_t next_q;

    // Samples are taken only on ticks; a one then a zero lets the count
    // advance at the following tick, so the fastest rate is two ticks.
    always_comb begin
        next_q = q;
        next_q.sync_a = i_pin;
        next_q.sync_b = q.sync_a;
        next_q.inc = 1'b0;
        if (i_tick) begin
            next_q.newer = q.sync_b;
            next_q.older = q.newer;
            next_q.inc = q.older && !q.newer;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_inc = q.inc;

endmodule

// ---- osc_tick.sv ----
module osc_tick #(
    parameter int DIVIDE = tmr_pkg::OSC_CYCLES_PER_TICK
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    output logic o_tick
);

    if (DIVIDE < 2 || DIVIDE > 255) begin : g_bad_divide
        $error("osc_tick divide out of range");
    end

    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } state_t;

    state_t q;
    state_t next_q;

    // The tick runs free so the timer rate ignores any bus activity.
    always_comb begin
        next_q = q;
        next_q.tick = 1'b0;
        if (q.count == 8'(DIVIDE - 1)) begin
            next_q.count = 8'h00;
            next_q.tick = 1'b1;
        end else begin
            next_q.count = q.count + 8'h01;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign o_tick = q.tick;

endmodule

// ---- pin_partner.sv ----
module pin_partner (
    input wire logic i_clk,
    output logic o_event_zero,
    output logic o_event_one,
    output logic o_irq_zero,
    output logic o_irq_one
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // Board-side pins
    // ------------------------------------------------------------
    // Interrupt pins idle high so that level sensing stays quiet until asked.
    initial begin
        o_event_zero = 1'b0;
        o_event_one = 1'b0;
        o_irq_zero = 1'b1;
        o_irq_one = 1'b1;
    end

    // Drives one interrupt pin, which also serves as the gate input.
    task automatic set_irq(input int idx, input logic val);
        @(posedge i_clk);
        if (idx == 0) begin
            o_irq_zero <= val;
        end else begin
            o_irq_one <= val;
        end
    endtask

    // Each level is held at least 24 clocks, two sample periods, so no level is missed.
    task automatic pulse_events(input int n);
        repeat (n) begin
            @(posedge i_clk);
            o_event_zero <= 1'b1;
            o_event_one <= 1'b1;
            repeat (24) @(posedge i_clk);
            o_event_zero <= 1'b0;
            o_event_one <= 1'b0;
            repeat (24) @(posedge i_clk);
        end
    endtask
endmodule

// ---- tmr_pkg.sv ----
package tmr_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SHARED_CONTROL = 8'h88;
    localparam logic [7:0] ADDR_MODE_SELECT = 8'h89;
    localparam logic [7:0] ADDR_COUNT_LOW_ZERO = 8'h8A;
    localparam logic [7:0] ADDR_COUNT_LOW_ONE = 8'h8B;
    localparam logic [7:0] ADDR_COUNT_HIGH_ZERO = 8'h8C;
    localparam logic [7:0] ADDR_COUNT_HIGH_ONE = 8'h8D;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_SHARED_CONTROL = 8'h00;
    localparam logic [7:0] RST_MODE_SELECT = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;

    // ------------------------------------------------------------
    // Shared control bit positions
    // ------------------------------------------------------------
    localparam int CTL_TRIGGER_TYPE_ZERO = 0;
    localparam int CTL_EXT_IRQ_FLAG_ZERO = 1;
    localparam int CTL_TRIGGER_TYPE_ONE = 2;
    localparam int CTL_EXT_IRQ_FLAG_ONE = 3;
    localparam int CTL_RUN_BIT_ZERO = 4;
    localparam int CTL_OVERFLOW_FLAG_ZERO = 5;
    localparam int CTL_RUN_BIT_ONE = 6;
    localparam int CTL_OVERFLOW_FLAG_ONE = 7;

    // ------------------------------------------------------------
    // Mode select field layout, one nibble per timer
    // ------------------------------------------------------------
    localparam int MODE_FIELD_LSB = 0;
    localparam int MODE_FUNC_BIT = 2;
    localparam int MODE_GATE_BIT = 3;
    localparam int MODE_NIBBLE_ONE = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int OSC_CYCLES_PER_TICK = 12;

    typedef enum logic [1:0] {
        MODE_PRESCALED_13 = 2'b00,
        MODE_CASCADED_16 = 2'b01,
        MODE_RELOAD_8 = 2'b10,
        MODE_SPLIT_STOP = 2'b11
    } mode_t;

endpackage
